/* File: include/dcc_consts.svh */
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define DCC_ADDR_CMP_CTRL    12'h000
`define DCC_ADDR_LADDER_CTRL 12'h004
`define DCC_ADDR_IRQ_STATUS  12'h008
`define DCC_ADDR_IRQ_MASK    12'h00C
`define DCC_ADDR_IDLE        12'h010

// ----------------------------------------------------------------
// comparator control fields
// ----------------------------------------------------------------
`define DCC_B_IDLE_STOP   15
`define DCC_B_SEC_FLAG    13
`define DCC_B_FIR_FLAG    12
`define DCC_B_SEC_ON      11
`define DCC_B_FIR_ON      10
`define DCC_B_SEC_PAD     9
`define DCC_B_FIR_PAD     8
`define DCC_B_SEC_RES     7
`define DCC_B_FIR_RES     6
`define DCC_B_SEC_INV     5
`define DCC_B_FIR_INV     4
`define DCC_B_SEC_MINUS   3
`define DCC_B_SEC_PLUS    2
`define DCC_B_FIR_MINUS   1
`define DCC_B_FIR_PLUS    0
`define DCC_CMP_WMASK     16'hBF3F

// ----------------------------------------------------------------
// ladder control fields
// ----------------------------------------------------------------
`define DCC_B_LAD_POWER   7
`define DCC_B_LAD_PIN     6
`define DCC_B_LAD_RANGE   5
`define DCC_B_LAD_SOURCE  4
`define DCC_LAD_WMASK     16'h00FF

// ----------------------------------------------------------------
// status, mask and idle fields
// ----------------------------------------------------------------
`define DCC_IRQ_WMASK     32'h0000_0003
`define DCC_IDLE_WMASK    32'h0000_0001
`define DCC_RESET16       16'h0000
`define DCC_RESET2        2'h0

`endif

/* File: include/dcc_pkg.sv */
package dcc_pkg;
    typedef enum logic [1:0] {
        DCC_APB_IDLE   = 2'b01,
        DCC_APB_ACCESS = 2'b10
    } dcc_apb_state_t;
endpackage

/* File: design/dcc_top.sv */
// How it works
// - idle-stop bit set and device idle: interrupt output held off, block runs.
// - bits 13/12 flag a change of second/first comparator result.
// - bits 11/10 switch second/first comparator on; zero switches it off.
// - bits 9/8 drive second/first result onto its pad; zero releases pad.
// - bit 7 reads second result, complemented when its invert bit is set.
// - bit 6 reads first result, complemented when its invert bit is set.
// - bits 5/4 invert second/first comparator output.
// - bits 3/1 route minus input from plus pin when 1, minus pin when 0.
// - bits 2/0 route plus input from plus pin when 1, reference when 0.
// - ladder bit 7 powers the reference ladder.
// - ladder bit 6 connects the reference level to its pin.
// - ladder bit 5 picks the range: 0..0.625 in /24 or 0.25..0.719 in /32.
// - ladder bit 4 picks external reference pins or analog supply as source.
// - 4-bit level picks one of 16 ladder taps.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"

module dcc_top
    import dcc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator cores
    input  wire logic        first_raw,
    input  wire logic        second_raw,
    input  wire logic        device_idle,
    output logic             first_cmp_on,
    output logic             second_cmp_on,
    output logic             first_minus_select,
    output logic             second_minus_select,
    output logic             first_plus_select,
    output logic             second_plus_select,
    // result pads (remappable pin side)
    output logic             first_pad_out,
    output logic             first_pad_oe,
    output logic             second_pad_out,
    output logic             second_pad_oe,
    // reference ladder
    output logic             ladder_power,
    output logic             ladder_pin_drive,
    output logic             ladder_range,
    output logic             ladder_source,
    output logic       [3:0] ladder_level,
    // interrupt
    output logic             cmp_irq
);
    import dcc_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0]    cmp_ctrl_r;
    logic [15:0]    lad_ctrl_r;
    logic [1:0]     irq_stat_r;
    logic [1:0]     irq_mask_r;
    logic           idle_r;
    logic [1:0]     meta_r;
    logic [1:0]     sync_r;
    logic [1:0]     prev_r;
    logic           sync_valid_r;
    dcc_apb_state_t apb_state_r;

    logic           wr_take;
    logic           rd_take;
    logic           addr_ok;
    logic [1:0]     result_now;
    logic [1:0]     change;
    logic [31:0]    rd_mux;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        hit = (a == b);
    endfunction

    // ----------------------------------------------------------------
    // apb handshake: one wait-free access phase
    // ----------------------------------------------------------------
    assign addr_ok = hit(paddr, `DCC_ADDR_CMP_CTRL) || hit(paddr, `DCC_ADDR_LADDER_CTRL)
                  || hit(paddr, `DCC_ADDR_IRQ_STATUS) || hit(paddr, `DCC_ADDR_IRQ_MASK)
                  || hit(paddr, `DCC_ADDR_IDLE);
    assign wr_take = psel && penable && pwrite && pready;
    assign rd_take = psel && !penable && !pwrite;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            apb_state_r <= DCC_APB_IDLE;
        else
        begin
            case (apb_state_r)
                DCC_APB_IDLE:   if (psel && !penable) apb_state_r <= DCC_APB_ACCESS;
                DCC_APB_ACCESS: apb_state_r <= DCC_APB_IDLE;
                default:        apb_state_r <= DCC_APB_IDLE;
            endcase
        end
    end

    // ready and error are registered off the setup cycle
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // ----------------------------------------------------------------
    // result synchroniser and change detect
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_r       <= `DCC_RESET2;
            sync_r       <= `DCC_RESET2;
            prev_r       <= `DCC_RESET2;
            sync_valid_r <= 1'b0;
        end
        else
        begin
            meta_r       <= {second_raw, first_raw};
            sync_r       <= meta_r;
            prev_r       <= sync_r;
            sync_valid_r <= 1'b1;
        end
    end

    // change detect uses raw samples, so toggling invert never flags
    assign result_now = {sync_r[1] ^ cmp_ctrl_r[`DCC_B_SEC_INV],
                         sync_r[0] ^ cmp_ctrl_r[`DCC_B_FIR_INV]};
    // off comparators never flag; sync_valid_r only masks the first cycle after reset, before the first sample reaches meta_r
    assign change = (sync_r ^ prev_r) & {cmp_ctrl_r[`DCC_B_SEC_ON], cmp_ctrl_r[`DCC_B_FIR_ON]}
                  & {2{sync_valid_r}};

    // ----------------------------------------------------------------
    // comparator control register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cmp_ctrl_r <= `DCC_RESET16;
        else
        begin
            if (wr_take && hit(paddr, `DCC_ADDR_CMP_CTRL))
                cmp_ctrl_r <= pwdata[15:0] & `DCC_CMP_WMASK;
            // set wins over a software clear in the same cycle
            if (change[1])
                cmp_ctrl_r[`DCC_B_SEC_FLAG] <= 1'b1;
            if (change[0])
                cmp_ctrl_r[`DCC_B_FIR_FLAG] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // ladder, mask, idle registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            lad_ctrl_r <= `DCC_RESET16;
        else if (wr_take && hit(paddr, `DCC_ADDR_LADDER_CTRL))
            lad_ctrl_r <= pwdata[15:0] & `DCC_LAD_WMASK;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_mask_r <= `DCC_RESET2;
        else if (wr_take && hit(paddr, `DCC_ADDR_IRQ_MASK))
            irq_mask_r <= pwdata[1:0];
    end

    // idle pin from the power manager is asynchronous to this clock
    logic idle_meta_r;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_meta_r <= 1'b0;
            idle_r      <= 1'b0;
        end
        else
        begin
            idle_meta_r <= device_idle;
            idle_r      <= idle_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // sticky interrupt status, write one to clear
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_stat_r <= `DCC_RESET2;
        else
        begin
            if (wr_take && hit(paddr, `DCC_ADDR_IRQ_STATUS))
                irq_stat_r <= (irq_stat_r & ~pwdata[1:0]) | change;
            else
                irq_stat_r <= irq_stat_r | change;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cmp_irq <= 1'b0;
        else
            cmp_irq <= |(irq_stat_r & irq_mask_r)
                       && !(cmp_ctrl_r[`DCC_B_IDLE_STOP] && idle_r);
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit(paddr, `DCC_ADDR_CMP_CTRL))
        begin
            rd_mux[15:0] = cmp_ctrl_r;
            rd_mux[`DCC_B_SEC_RES] = result_now[1];
            rd_mux[`DCC_B_FIR_RES] = result_now[0];
        end
        else if (hit(paddr, `DCC_ADDR_LADDER_CTRL))
            rd_mux[15:0] = lad_ctrl_r;
        else if (hit(paddr, `DCC_ADDR_IRQ_STATUS))
            rd_mux[1:0] = irq_stat_r;
        else if (hit(paddr, `DCC_ADDR_IRQ_MASK))
            rd_mux[1:0] = irq_mask_r;
        else if (hit(paddr, `DCC_ADDR_IDLE))
            rd_mux[0] = idle_r;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (rd_take)
            prdata <= rd_mux;
    end

    // ----------------------------------------------------------------
    // analog and pad controls, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            first_cmp_on        <= 1'b0;
            second_cmp_on       <= 1'b0;
            first_minus_select  <= 1'b0;
            second_minus_select <= 1'b0;
            first_plus_select   <= 1'b0;
            second_plus_select  <= 1'b0;
            first_pad_out       <= 1'b0;
            first_pad_oe        <= 1'b0;
            second_pad_out      <= 1'b0;
            second_pad_oe       <= 1'b0;
            ladder_power        <= 1'b0;
            ladder_pin_drive    <= 1'b0;
            ladder_range        <= 1'b0;
            ladder_source       <= 1'b0;
            ladder_level        <= 4'h0;
        end
        else
        begin
            first_cmp_on        <= cmp_ctrl_r[`DCC_B_FIR_ON];
            second_cmp_on       <= cmp_ctrl_r[`DCC_B_SEC_ON];
            first_minus_select  <= cmp_ctrl_r[`DCC_B_FIR_MINUS];
            second_minus_select <= cmp_ctrl_r[`DCC_B_SEC_MINUS];
            first_plus_select   <= cmp_ctrl_r[`DCC_B_FIR_PLUS];
            second_plus_select  <= cmp_ctrl_r[`DCC_B_SEC_PLUS];
            // pin mapping is software's job before the pad is enabled
            first_pad_out       <= result_now[0];
            first_pad_oe        <= cmp_ctrl_r[`DCC_B_FIR_PAD];
            second_pad_out      <= result_now[1];
            second_pad_oe       <= cmp_ctrl_r[`DCC_B_SEC_PAD];
            ladder_power        <= lad_ctrl_r[`DCC_B_LAD_POWER];
            ladder_pin_drive    <= lad_ctrl_r[`DCC_B_LAD_PIN];
            ladder_range        <= lad_ctrl_r[`DCC_B_LAD_RANGE];
            ladder_source       <= lad_ctrl_r[`DCC_B_LAD_SOURCE];
            ladder_level        <= lad_ctrl_r[3:0];
        end
    end

endmodule
`default_nettype wire

/* File: tb/dcc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module dcc_assertions (
    // clock, reset, apb
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // comparator cores and pads
    input wire logic        first_cmp_on,
    input wire logic        second_cmp_on,
    input wire logic        first_minus_select,
    input wire logic        second_minus_select,
    input wire logic        first_plus_select,
    input wire logic        second_plus_select,
    input wire logic        first_pad_oe,
    input wire logic        second_pad_oe,
    // ladder and interrupt
    input wire logic        ladder_power,
    input wire logic        ladder_pin_drive,
    input wire logic        ladder_range,
    input wire logic        ladder_source,
    input wire logic  [3:0] ladder_level,
    input wire logic        cmp_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic acc;
    assign acc = psel && penable && pready;
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_err_unmapped: assert property (acc && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_read_upper: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_ladder_upper: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata[15:8] == 8'h0)
        else $error("ladder upper byte not zero");
    // latency 2, checked at 3 so a following write cannot disturb it
    a_cmp_copy: assert property (acc && pwrite && paddr == 12'h000 |-> ##3
        {second_cmp_on, first_cmp_on, second_pad_oe, first_pad_oe} == $past(pwdata[11:8], 3)
        && {second_minus_select, second_plus_select, first_minus_select, first_plus_select}
        == $past(pwdata[3:0], 3))
        else $error("control ports differ from write");
    a_ladder_copy: assert property (acc && pwrite && paddr == 12'h004 |-> ##3
        {ladder_power, ladder_pin_drive, ladder_range, ladder_source, ladder_level}
        == $past(pwdata[7:0], 3))
        else $error("ladder ports differ from write");
    c_write: cover property (acc && pwrite);
    c_irq: cover property ($rose(cmp_irq));
    c_err: cover property (acc && pslverr);
endmodule
`default_nettype wire

/* File: tb/dcc_cmp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// comparator core, voltages in source/96
// ----------------------------------------
module dcc_cmp_model (
    // control
    input  wire logic       on,
    input  wire logic       plus_sel,
    input  wire logic       minus_sel,
    input  wire logic       lad_power,
    input  wire logic       lad_range,
    input  wire logic [3:0] lad_level,
    // pin voltages
    input  wire logic [6:0] pin_plus,
    input  wire logic [6:0] pin_minus,
    // result
    output logic            raw
);
    logic [6:0] ref_v;
    logic [6:0] vp;
    logic [6:0] vm;
    always_comb
    begin
        ref_v = lad_range ? {1'b0, lad_level, 2'b00} : 7'h18 + 7'(lad_level) * 7'h03;
        if (!lad_power)
            ref_v = 7'h00;
        vp = plus_sel ? pin_plus : ref_v;
        vm = minus_sel ? pin_plus : pin_minus;
        // a core that is off is held low here, not left floating
        raw = on && (vp > vm);
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, device_idle, cmp_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic first_raw, second_raw, first_cmp_on, second_cmp_on, first_pad_oe, second_pad_oe;
    logic first_minus_select, second_minus_select, first_plus_select, second_plus_select;
    logic first_pad_out, second_pad_out, ladder_power, ladder_pin_drive, ladder_range;
    logic ladder_source;
    logic [3:0] ladder_level;
    logic [6:0] p1p, p1m, p2p, p2m;
    int miscompares, n_compared;
    dcc_top dcc_top_i (.*);
    dcc_cmp_model m1 (.on(first_cmp_on), .plus_sel(first_plus_select),
        .minus_sel(first_minus_select), .lad_power(ladder_power), .lad_range(ladder_range),
        .lad_level(ladder_level), .pin_plus(p1p), .pin_minus(p1m), .raw(first_raw));
    dcc_cmp_model m2 (.on(second_cmp_on), .plus_sel(second_plus_select),
        .minus_sel(second_minus_select), .lad_power(ladder_power), .lad_range(ladder_range),
        .lad_level(ladder_level), .pin_plus(p2p), .pin_minus(p2m), .raw(second_raw));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; ends one idle edge later so calls may follow directly
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        // look at the answer mid-cycle, where it has settled
        do
        begin
            @(negedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
            miscompares++;
        rdata = prdata;
        chk("pslverr", {31'h0, a > 12'h010}, {31'h0, pslverr});
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    logic [31:0] lad_pat [3] = '{32'hFFFF_FFFF, 32'h5A, 32'hA5};
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdata);
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_regs();
        rdc("ctrl rst", 12'h000, 32'h0);
        rdc("ladder rst", 12'h004, 32'h0);
        xfer(1'b1, 12'h000, 32'hFFFF_FFFF);
        rdc("ctrl all", 12'h000, 32'hBFFF);
        chk("ctrl pins", 32'hFF, {second_cmp_on, first_cmp_on, second_pad_oe, first_pad_oe,
            second_minus_select, second_plus_select, first_minus_select, first_plus_select});
        chk("pads inv", 32'h3, {second_pad_out, first_pad_out});
        xfer(1'b1, 12'h000, 32'h0);
        rdc("ctrl clr", 12'h000, 32'h0);
        foreach (lad_pat[i])
        begin
            xfer(1'b1, 12'h004, lad_pat[i]);
            rdc("ladder", 12'h004, lad_pat[i] & 32'hFF);
            chk("ladder pins", lad_pat[i] & 32'hFF, {ladder_power, ladder_pin_drive,
                ladder_range, ladder_source, ladder_level});
        end
        xfer(1'b0, 12'h020, 32'h0);
        chk("unmapped data", 32'h0, rdata);
    endtask
    task automatic t_event();
        xfer(1'b1, 12'h00C, 32'h3);
        xfer(1'b1, 12'h004, 32'h85);
        xfer(1'b1, 12'h000, 32'h0500);
        p1m <= 7'd30;
        repeat (6) @(posedge ref_clk);
        rdc("flag set", 12'h000, 32'h1540);
        chk("irq on", 32'h1, {31'h0, cmp_irq});
        chk("pad", 32'h1, {31'h0, first_pad_out});
        xfer(1'b1, 12'h008, 32'h3);
        xfer(1'b1, 12'h000, 32'h0510);
        repeat (3) @(posedge ref_clk);
        chk("irq off", 32'h0, {31'h0, cmp_irq});
        rdc("inverted", 12'h000, 32'h0510);
        xfer(1'b1, 12'h004, 32'hA5);
        repeat (6) @(posedge ref_clk);
        rdc("range", 12'h000, 32'h1550);
        xfer(1'b1, 12'h000, 32'h0);
        xfer(1'b1, 12'h008, 32'h3);
    endtask
    task automatic t_idle();
        device_idle <= 1'b1;
        xfer(1'b1, 12'h000, 32'h8804);
        xfer(1'b1, 12'h008, 32'h3);
        p2p <= 7'd30;
        repeat (6) @(posedge ref_clk);
        chk("irq idle", 32'h0, {31'h0, cmp_irq});
        rdc("idle flag", 12'h000, 32'hA884);
        device_idle <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("irq wake", 32'h1, {31'h0, cmp_irq});
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        {psel, penable, pwrite, device_idle} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        {p1p, p1m, p2p, p2m} = {7'd0, 7'd50, 7'd10, 7'd20};
        miscompares = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_event();
        t_idle();
        results();
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        results();
    end
endmodule
bind dcc_top dcc_assertions dcc_assertions_i (.*);
`default_nettype wire
